// ---- src/rtc_supervisor.sv ----
// Real-time clock supervisor: register file, oscillator check, alarm,
// watchdog, power-fail flag and the interrupt pin driver.
// Assumes bus, supply and time inputs are synchronous to clk_i and that
// the time-of-day counters live outside and advance on sec_tick_o.
//
// Overview of operation
// - Oscillator runs while the disable bit is 0, stops when 1; ships cleared.
// - At power-on with oscillator enabled, no oscillation in 5 ms sets fail flag.
// - Setting the fail flag reloads time counters from the stored base time.
// - Alarm and flag control writes take effect only while write-enable is 1.
// - Five low calibration bits give magnitude; bit 5 set subtracts counts.
// - Over 64 minutes, first 2N minutes each alter one second by 256 or 128.
// - Calibration test bit toggles interrupt pin at raw 512 Hz.
// - Calibration and interrupt config are non-volatile, factory value 00h.
// - Alarm match against time sets alarm flag, interrupts if enabled.
// - Alarm register with MSB set is left out of the comparison.
// - Watchdog counts down on a 32 Hz crystal tick, idle when stopped.
// - Watchdog reaching zero sets timeout flag, interrupts if enabled.
// - Writing 1 to reload strobe reloads the watchdog counter.
// - Load value accepted only while load lock is 0; host toggles lock.
// - A zero load value disables the watchdog entirely.
// - Supply-fail indication sets supply-fail flag, interrupts if enabled.
// - Polarity 1 gives active-high push-pull; 0 gives active-low open-drain.
// - Pulse mode drives about 200 ms or until flags read; level until read.
// - Reading flags clears timeout, alarm and supply-fail flags.
// - Power-up clears flags except the oscillator-fail bit.
`timescale 1ns/1ns
`default_nettype none
module rtc_supervisor
  import rtc_pkg::*;
#(
  parameter int OSC_WAIT_CYCLES = OSC_WAIT_CYC,
  parameter int PULSE_CYCLES    = PULSE_CYC
) (
  // Clock and resets
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        factory_init_i,
  // Byte-wide parallel bus
  input  wire logic [14:0] addr_i,
  input  wire logic        ce_n_i,
  input  wire logic        we_n_i,
  input  wire logic        oe_n_i,
  input  wire logic [7:0]  dq_i,
  output logic [7:0]       dq_o,
  output logic             dq_oe_o,
  // Crystal and supply monitor
  input  wire logic        osc_clk_i,
  output logic             osc_run_o,
  input  wire logic        supply_ok_i,
  input  wire logic        supply_fail_i,
  // Running time from the time-of-day counters
  input  wire logic [7:0]  rtc_sec_i,
  input  wire logic [7:0]  rtc_min_i,
  input  wire logic [7:0]  rtc_hour_i,
  input  wire logic [7:0]  rtc_day_i,
  output logic             sec_tick_o,
  output logic             base_reload_o,
  // Interrupt pin
  output logic             int_o,
  output logic             int_oe_o
);

  logic [7:0]  flags_q, flags_d;
  logic [7:0]  int_cfg_q, int_cfg_d;
  logic [7:0]  cal_q, cal_d;
  logic [7:0]  alarm_q [4], alarm_d [4];
  logic        wd_lock_q, wd_lock_d;
  logic [5:0]  wd_load_q, wd_load_d;
  logic        wd_reload;
  logic [7:0]  rdata_q, rdata_d;
  logic        rd_q, wr_q, ok_q, fail_q, tick_q, reload_q;
  logic        rd_act, wr_act, rd_go, wr_go, flags_rd, in_map;
  chk_state_t  chk_q, chk_d;
  logic [23:0] chk_cnt_q, chk_cnt_d;
  logic        osc_fail_set;
  logic        int_act_q, int_act_d;
  logic [23:0] pcnt_q, pcnt_d;
  logic        osc_edge, sec_tick, wd_tick, test_wave, wd_expire;
  logic [5:0]  wd_count;
  logic [3:0]  lane_hit;
  logic        alarm_hit, pf_rise, irq_event, int_assert;
  logic [7:0]  now [4];

  assign rd_act   = ~ce_n_i & ~oe_n_i & we_n_i;
  assign wr_act   = ~ce_n_i & ~we_n_i;
  assign rd_go    = rd_act & ~rd_q;
  assign wr_go    = wr_act & ~wr_q;
  assign in_map   = addr_i >= FLAGS_ADDR && addr_i <= CAL_ADDR;
  assign flags_rd = rd_go & (addr_i == FLAGS_ADDR);
  assign pf_rise  = supply_fail_i & ~fail_q;
  assign now      = '{rtc_sec_i, rtc_min_i, rtc_hour_i, rtc_day_i};

  assign osc_run_o = ~cal_q[CAL_OFF];

  osc_divider u_div (
    .clk_i       (clk_i),
    .reset_i     (reset_i),
    .osc_clk_i   (osc_clk_i),
    .osc_en_i    (osc_run_o),
    .cal_mag_i   (cal_q[4:0]),
    .cal_pos_i   (cal_q[CAL_SIGN]),
    .osc_edge_o  (osc_edge),
    .sec_tick_o  (sec_tick),
    .wd_tick_o   (wd_tick),
    .test_wave_o (test_wave)
  );

  wdog_counter u_wd (
    .clk_i    (clk_i),
    .reset_i  (reset_i),
    .tick_i   (wd_tick),
    .reload_i (wd_reload),
    .load_i   (wd_load_q),
    .expire_o (wd_expire),
    .count_o  (wd_count)
  );

  genvar g;
  for (g = 0; g < 4; g++) begin : g_lane
    assign lane_hit[g] = alarm_q[g][ALARM_MASK] || alarm_q[g][6:0] == now[g][6:0];
  end
  assign alarm_hit = tick_q & (&lane_hit);
  assign sec_tick_o = sec_tick;

  // Register file and flags
  always_comb begin
    flags_d   = flags_q;
    int_cfg_d = int_cfg_q;
    cal_d     = cal_q;
    alarm_d   = alarm_q;
    wd_lock_d = wd_lock_q;
    wd_load_d = wd_load_q;
    wd_reload = 1'b0;
    rdata_d   = rdata_q;
    if (wr_go) begin
      case (addr_i)
        FLAGS_ADDR: begin
          flags_d[FLG_W] = dq_i[FLG_W];
          if (flags_q[FLG_W]) begin
            flags_d[FLG_CAL] = dq_i[FLG_CAL];
            flags_d[FLG_R]   = dq_i[FLG_R];
            if (!dq_i[FLG_OSC_FAIL_FLAG]) flags_d[FLG_OSC_FAIL_FLAG] = 1'b0;
          end
        end
        ALARM_SEC_ADDR: if (flags_q[FLG_W]) alarm_d[0] = dq_i;
        ALARM_MIN_ADDR: if (flags_q[FLG_W]) alarm_d[1] = dq_i;
        ALARM_HR_ADDR:  if (flags_q[FLG_W]) alarm_d[2] = dq_i;
        ALARM_DAY_ADDR: if (flags_q[FLG_W]) alarm_d[3] = dq_i;
        INT_CFG_ADDR:   int_cfg_d = dq_i & INT_CFG_WMASK;
        WDOG_ADDR: begin
          wd_lock_d = dq_i[WD_LOCK];
          if (!wd_lock_q) wd_load_d = dq_i[5:0];
          wd_reload = dq_i[WD_STROBE];
        end
        CAL_ADDR:       cal_d = dq_i & CAL_WMASK;
        default:        flags_d = flags_q;
      endcase
    end
    if (flags_rd) begin
      flags_d[FLG_WDF] = 1'b0;
      flags_d[FLG_AF]  = 1'b0;
      flags_d[FLG_PF]  = 1'b0;
    end
    if (wd_expire) flags_d[FLG_WDF] = 1'b1;
    if (alarm_hit) flags_d[FLG_AF] = 1'b1;
    if (pf_rise) flags_d[FLG_PF] = 1'b1;
    if (osc_fail_set) flags_d[FLG_OSC_FAIL_FLAG] = 1'b1;
    if (rd_go) begin
      case (addr_i)
        FLAGS_ADDR:     rdata_d = flags_q;
        ALARM_SEC_ADDR: rdata_d = alarm_q[0];
        ALARM_MIN_ADDR: rdata_d = alarm_q[1];
        ALARM_HR_ADDR:  rdata_d = alarm_q[2];
        ALARM_DAY_ADDR: rdata_d = alarm_q[3];
        INT_CFG_ADDR:   rdata_d = int_cfg_q;
        WDOG_ADDR:      rdata_d = {1'b0, wd_lock_q, wd_load_q};
        CAL_ADDR:       rdata_d = cal_q;
        default:        rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      // power-up clears all but fail bit
      flags_q   <= FLAGS_RESET | (flags_q & (8'h01 << FLG_OSC_FAIL_FLAG));
      alarm_q   <= '{ALARM_RESET, ALARM_RESET, ALARM_RESET, ALARM_RESET};
      wd_lock_q <= 1'b1;
      wd_load_q <= WD_LOAD_RST;
      rdata_q   <= 8'h00;
      rd_q      <= 1'b0;
      wr_q      <= 1'b0;
      ok_q      <= 1'b0;
      fail_q    <= 1'b0;
      tick_q    <= 1'b0;
      reload_q  <= 1'b0;
    end else begin
      flags_q   <= flags_d;
      alarm_q   <= alarm_d;
      wd_lock_q <= wd_lock_d;
      wd_load_q <= wd_load_d;
      rdata_q   <= rdata_d;
      rd_q      <= rd_act;
      wr_q      <= wr_act;
      ok_q      <= supply_ok_i;
      fail_q    <= supply_fail_i;
      tick_q    <= sec_tick;
      reload_q  <= osc_fail_set;
    end
    if (factory_init_i) begin
      int_cfg_q <= NV_RESET;
      cal_q     <= NV_RESET;
      flags_q   <= FLAGS_RESET;
    end else if (!reset_i) begin
      int_cfg_q <= int_cfg_d;
      cal_q     <= cal_d;
    end
  end

  assign dq_o    = rdata_q;
  assign dq_oe_o = rd_act & rd_q & in_map;
  assign base_reload_o = reload_q;

  // Oscillator start check
  always_comb begin
    chk_d        = chk_q;
    chk_cnt_d    = chk_cnt_q;
    osc_fail_set = 1'b0;
    case (chk_q)
      CHK_IDLE: begin
        if (supply_ok_i && !ok_q && osc_run_o) begin
          chk_d     = CHK_WAIT;
          chk_cnt_d = 24'h000000;
        end
      end
      CHK_WAIT: begin
        if (osc_edge) begin
          chk_d = CHK_IDLE;
        end else if (chk_cnt_q == 24'(OSC_WAIT_CYCLES - 1)) begin
          osc_fail_set = 1'b1;
          chk_d        = CHK_IDLE;
        end else begin
          chk_cnt_d = chk_cnt_q + 24'h000001;
        end
      end
      default: chk_d = CHK_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      chk_q     <= CHK_IDLE;
      chk_cnt_q <= 24'h000000;
    end else begin
      chk_q     <= chk_d;
      chk_cnt_q <= chk_cnt_d;
    end
  end

  // Interrupt pin
  assign irq_event = (wd_expire & int_cfg_q[INT_WIE]) | (alarm_hit & int_cfg_q[INT_AIE])
                   | (pf_rise & int_cfg_q[INT_PFE]);

  always_comb begin
    int_act_d = int_act_q;
    pcnt_d    = pcnt_q;
    // pulse or level, read ends it
    if (irq_event) begin
      int_act_d = 1'b1;
      pcnt_d    = 24'(PULSE_CYCLES - 1);
    end else if (flags_rd) begin
      int_act_d = 1'b0;
    end else if (int_act_q && int_cfg_q[INT_PL]) begin
      if (pcnt_q == 24'h000000) int_act_d = 1'b0;
      else pcnt_d = pcnt_q - 24'h000001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      int_act_q <= 1'b0;
      pcnt_q    <= 24'h000000;
    end else begin
      int_act_q <= int_act_d;
      pcnt_q    <= pcnt_d;
    end
  end

  assign int_assert = flags_q[FLG_CAL] ? test_wave : int_act_q;
  assign int_o    = int_cfg_q[INT_HL] & int_assert;
  assign int_oe_o = int_cfg_q[INT_HL] | int_assert;

  // Checks
  sequence s_flags_read;
    flags_rd && !wd_expire && !alarm_hit && !pf_rise;
  endsequence

  property p_rd_clear;
    @(posedge clk_i) disable iff (reset_i)
      s_flags_read |=> !flags_q[FLG_WDF] && !flags_q[FLG_AF] && !flags_q[FLG_PF];
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("flags not cleared by read");

  property p_wdf;
    @(posedge clk_i) disable iff (reset_i) wd_expire |=> flags_q[FLG_WDF];
  endproperty
  a_wdf: assert property (p_wdf) else $error("timeout flag not set");

  property p_af;
    @(posedge clk_i) disable iff (reset_i) alarm_hit |=> flags_q[FLG_AF];
  endproperty
  a_af: assert property (p_af) else $error("alarm flag not set");

  property p_pf;
    @(posedge clk_i) disable iff (reset_i) $rose(supply_fail_i) |=> flags_q[FLG_PF];
  endproperty
  a_pf: assert property (p_pf) else $error("supply fail flag not set");

  property p_osc_fail_flag;
    @(posedge clk_i) disable iff (reset_i)
      osc_fail_set |=> flags_q[FLG_OSC_FAIL_FLAG] && base_reload_o;
  endproperty
  a_osc_fail_flag: assert property (p_osc_fail_flag) else $error("fail flag or base reload missing");

  property p_lock;
    @(posedge clk_i) disable iff (reset_i)
      wr_go && addr_i == WDOG_ADDR && wd_lock_q |=> $stable(wd_load_q);
  endproperty
  a_lock: assert property (p_lock) else $error("load changed while locked");

  property p_alarm_wr;
    @(posedge clk_i) disable iff (reset_i)
      wr_go && addr_i == ALARM_SEC_ADDR && !flags_q[FLG_W] |=> $stable(alarm_q[0]);
  endproperty
  a_alarm_wr: assert property (p_alarm_wr) else $error("alarm written while protected");

  property p_reload;
    @(posedge clk_i) disable iff (reset_i) wd_reload |=> wd_count == $past(wd_load_q);
  endproperty
  a_reload: assert property (p_reload) else $error("watchdog not reloaded");

  property p_level;
    @(posedge clk_i) disable iff (reset_i)
      int_act_q && !int_cfg_q[INT_PL] && !flags_rd [*2] |-> ##1 int_act_q;
  endproperty
  a_level: assert property (p_level) else $error("level interrupt dropped early");

  property p_open_drain;
    @(posedge clk_i) disable iff (reset_i)
      !int_cfg_q[INT_HL] |-> !int_o && (int_oe_o == int_assert);
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open-drain drive wrong");

endmodule
`default_nettype wire

// ---- include/rtc_pkg.sv ----
// Constants shared by the supervisor, its oscillator divider and its watchdog.
// Assumes a 50 MHz core clock and a 32.768 kHz crystal clock on a pin.
package rtc_pkg;

  // Register addresses on the byte-wide bus
  localparam logic [14:0] FLAGS_ADDR     = 15'h7ff0;
  localparam logic [14:0] ALARM_SEC_ADDR = 15'h7ff2;
  localparam logic [14:0] ALARM_MIN_ADDR = 15'h7ff3;
  localparam logic [14:0] ALARM_HR_ADDR  = 15'h7ff4;
  localparam logic [14:0] ALARM_DAY_ADDR = 15'h7ff5;
  localparam logic [14:0] INT_CFG_ADDR   = 15'h7ff6;
  localparam logic [14:0] WDOG_ADDR      = 15'h7ff7;
  localparam logic [14:0] CAL_ADDR       = 15'h7ff8;

  // flags_status fields
  localparam int FLG_WDF  = 7;
  localparam int FLG_AF   = 6;
  localparam int FLG_PF   = 5;
  localparam int FLG_OSC_FAIL_FLAG = 4;
  localparam int FLG_CAL  = 2;
  localparam int FLG_W    = 1;
  localparam int FLG_R    = 0;

  // interrupt_config fields
  localparam int INT_WIE = 7;
  localparam int INT_AIE = 6;
  localparam int INT_PFE = 5;
  localparam int INT_HL  = 3;
  localparam int INT_PL  = 2;
  localparam logic [7:0] INT_CFG_WMASK = 8'hec;

  // watchdog_control, oscillator_calibration and alarm fields
  localparam int WD_STROBE = 7;
  localparam int WD_LOCK   = 6;
  localparam int CAL_OFF   = 7;
  localparam int CAL_SIGN  = 5;
  localparam logic [7:0] CAL_WMASK = 8'hbf;
  localparam int ALARM_MASK = 7;

  // Reset values
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] NV_RESET    = 8'h00;
  localparam logic [7:0] ALARM_RESET = 8'h00;
  localparam logic [5:0] WD_LOAD_RST = 6'h00;

  // Oscillator divider
  localparam logic [16:0] SEC_TERM      = 17'h07fff;
  localparam logic [16:0] CAL_SHORT     = 17'h00080;
  localparam logic [16:0] CAL_LONG      = 17'h00100;
  localparam logic [5:0]  SEC_LAST      = 6'h3b;
  localparam logic [5:0]  MIN_LAST      = 6'h3f;
  localparam logic [9:0]  WD_TICK_LAST  = 10'h3ff;
  localparam int          TEST_WAVE_BIT = 5;

  // Timing
  localparam longint CLK_HZ      = 50000000;
  localparam longint OSC_WAIT_MS = 5;
  localparam longint PULSE_MS    = 200;
  localparam int OSC_WAIT_CYC = int'((OSC_WAIT_MS * CLK_HZ) / 1000);
  localparam int PULSE_CYC    = int'((PULSE_MS * CLK_HZ) / 1000);

  typedef enum logic [0:0] {
    CHK_IDLE = 1'b0,
    CHK_WAIT = 1'b1
  } chk_state_t;

endpackage

// ---- src/osc_divider.sv ----
// Crystal divider: synchronises the crystal clock, makes calibrated seconds,
// the 32 Hz watchdog tick and the uncalibrated 512 Hz test wave.
// Assumes osc_clk_i is a slow free-standing clock, sampled here by clk_i.
`timescale 1ns/1ns
`default_nettype none
module osc_divider
  import rtc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  // Crystal and calibration
  input  wire logic       osc_clk_i,
  input  wire logic       osc_en_i,
  input  wire logic [4:0] cal_mag_i,
  input  wire logic       cal_pos_i,
  // Ticks
  output logic            osc_edge_o,
  output logic            sec_tick_o,
  output logic            wd_tick_o,
  output logic            test_wave_o
);

  logic [2:0]  sync_q, sync_d;
  logic [16:0] sub_q, sub_d;
  logic [5:0]  sec_q, sec_d;
  logic [5:0]  min_q, min_d;
  logic [9:0]  raw_q, raw_d;
  logic        sec_tick_q, sec_tick_d;
  logic        wd_tick_q, wd_tick_d;
  logic        edge_now;
  logic [16:0] term;

  assign edge_now = osc_en_i & sync_q[1] & ~sync_q[2];

  always_comb begin
    sync_d     = {sync_q[1:0], osc_clk_i};
    sub_d      = sub_q;
    sec_d      = sec_q;
    min_d      = min_q;
    raw_d      = raw_q;
    sec_tick_d = 1'b0;
    wd_tick_d  = 1'b0;
    term       = SEC_TERM;
    if (sec_q == 6'h00 && min_q < {cal_mag_i, 1'b0}) begin
      term = cal_pos_i ? SEC_TERM - CAL_SHORT : SEC_TERM + CAL_LONG;
    end
    if (edge_now) begin
      raw_d     = raw_q + 10'h001;
      wd_tick_d = (raw_q == WD_TICK_LAST);
      if (sub_q >= term) begin
        sub_d      = 17'h00000;
        sec_tick_d = 1'b1;
        sec_d      = (sec_q == SEC_LAST) ? 6'h00 : sec_q + 6'h01;
        if (sec_q == SEC_LAST) begin
          min_d = (min_q == MIN_LAST) ? 6'h00 : min_q + 6'h01;
        end
      end else begin
        sub_d = sub_q + 17'h00001;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sync_q     <= 3'h0;
      sub_q      <= 17'h00000;
      sec_q      <= 6'h00;
      min_q      <= 6'h00;
      raw_q      <= 10'h000;
      sec_tick_q <= 1'b0;
      wd_tick_q  <= 1'b0;
    end else begin
      sync_q     <= sync_d;
      sub_q      <= sub_d;
      sec_q      <= sec_d;
      min_q      <= min_d;
      raw_q      <= raw_d;
      sec_tick_q <= sec_tick_d;
      wd_tick_q  <= wd_tick_d;
    end
  end

  assign osc_edge_o  = edge_now;
  assign sec_tick_o  = sec_tick_q;
  assign wd_tick_o   = wd_tick_q;
  assign test_wave_o = raw_q[TEST_WAVE_BIT];

endmodule
`default_nettype wire

// ---- src/wdog_counter.sv ----
// Watchdog down-counter on the 32 Hz tick.
// Assumes tick_i is a one-cycle pulse that stops when the crystal stops.
`timescale 1ns/1ns
`default_nettype none
module wdog_counter
  import rtc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  // Control
  input  wire logic       tick_i,
  input  wire logic       reload_i,
  input  wire logic [5:0] load_i,
  // Status
  output logic            expire_o,
  output logic [5:0]      count_o
);

  logic [5:0] cnt_q, cnt_d;
  logic       exp_q, exp_d;

  always_comb begin
    cnt_d = cnt_q;
    exp_d = 1'b0;
    if (reload_i) begin
      cnt_d = load_i;
    end else if (tick_i && cnt_q != 6'h00 && load_i != 6'h00) begin
      cnt_d = cnt_q - 6'h01;
      exp_d = (cnt_q == 6'h01);
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cnt_q <= WD_LOAD_RST;
      exp_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      exp_q <= exp_d;
    end
  end

  assign expire_o = exp_q;
  assign count_o  = cnt_q;

endmodule
`default_nettype wire

// ---- verif/host_model.sv ----
// Host model: byte-wide bus master that reaches the supervisor registers.
// Assumes clk_i is the design clock; signals change 1 ns after an edge.
`timescale 1ns/1ns
`default_nettype none
module host_model (
  // Clock
  input  wire logic        clk_i,
  // Bus
  output logic [14:0]      addr_o,
  output logic             ce_n_o,
  output logic             we_n_o,
  output logic             oe_n_o,
  output logic [7:0]       dq_o,
  input  wire logic [7:0]  dq_i
);
  initial begin
    addr_o = 15'h0000;
    ce_n_o = 1'b1;
    we_n_o = 1'b1;
    oe_n_o = 1'b1;
    dq_o   = 8'h00;
  end

  // Write: held over one taking edge, then released with data inverted
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    @(posedge clk_i) #1;
    addr_o = a;
    dq_o   = d;
    ce_n_o = 1'b0;
    we_n_o = 1'b0;
    @(posedge clk_i) #1;
    ce_n_o = 1'b1;
    we_n_o = 1'b1;
    dq_o   = ~d;
    addr_o = ~a;
  endtask

  // Read: data is taken once the answer edge has settled
  task automatic rd(input logic [14:0] a, output logic [7:0] d);
    @(posedge clk_i) #1;
    addr_o = a;
    ce_n_o = 1'b0;
    oe_n_o = 1'b0;
    @(posedge clk_i);
    @(posedge clk_i) #1;
    d      = dq_i;
    ce_n_o = 1'b1;
    oe_n_o = 1'b1;
    addr_o = ~a;
  endtask
endmodule
`default_nettype wire

// ---- verif/tb.sv ----
// Testbench for the supervisor: host model on the bus, crystal and supply
// driven here. Assumes a 50 MHz clock and a fast crystal to keep runs short.
`timescale 1ns/1ns
`default_nettype none
`define CHK(act, exp) begin n_checks++; if ((act) !== (exp)) begin n_mismatch++; \
  $display("unexpected at %0t: got %h expected %h", $time, act, exp); end end
module tb;
  import rtc_pkg::*;
  localparam int PULSE = 16;
  logic clk_i = 1'b0, reset_i = 1'b1, factory_init_i = 1'b1;
  logic supply_ok_i = 1'b0, supply_fail_i = 1'b0, osc_clk_i = 1'b0, osc_on = 1'b0;
  logic [7:0] rtc_sec_i, rtc_min_i, rtc_hour_i, rtc_day_i, dq_i, dq_o, d, v;
  logic [14:0] addr_i;
  logic ce_n_i, we_n_i, oe_n_i, dq_oe_o, osc_run_o, sec_tick_o, base_reload_o;
  logic int_o, int_oe_o, hl, seen;
  logic [31:0] lfsr = 32'ha3dc;
  logic [7:0] cfgs [3] = '{8'h28, 8'h2c, 8'h20};
  int n_mismatch = 0, n_checks = 0, tog;

  always #10 clk_i = ~clk_i;
  always #20 if (osc_on) osc_clk_i = ~osc_clk_i;

  host_model i_host (.clk_i(clk_i), .addr_o(addr_i), .ce_n_o(ce_n_i), .we_n_o(we_n_i),
    .oe_n_o(oe_n_i), .dq_o(dq_i), .dq_i(dq_o));
  rtc_supervisor #(.OSC_WAIT_CYCLES(20), .PULSE_CYCLES(PULSE)) i_dut (.clk_i(clk_i),
    .reset_i(reset_i), .factory_init_i(factory_init_i), .addr_i(addr_i),
    .ce_n_i(ce_n_i), .we_n_i(we_n_i), .oe_n_i(oe_n_i), .dq_i(dq_i), .dq_o(dq_o),
    .dq_oe_o(dq_oe_o), .osc_clk_i(osc_clk_i), .osc_run_o(osc_run_o),
    .supply_ok_i(supply_ok_i), .supply_fail_i(supply_fail_i), .rtc_sec_i(rtc_sec_i),
    .rtc_min_i(rtc_min_i), .rtc_hour_i(rtc_hour_i), .rtc_day_i(rtc_day_i),
    .sec_tick_o(sec_tick_o), .base_reload_o(base_reload_o), .int_o(int_o),
    .int_oe_o(int_oe_o));

  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // Asserted level of the pin as the polarity bit defines it
  function automatic logic asserted(input logic h, input logic o, input logic oe);
    return h ? (o & oe) : (oe & ~o);
  endfunction

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Bounded wait on the pin (sel=1) or the base reload pulse (sel=0)
  task automatic wait_for(input logic sel, input int lim);
    for (int i = 0; i < lim; i++) begin
      @(posedge clk_i) #1;
      if ((sel ? int_o : base_reload_o) === 1'b1)
        return;
    end
    n_mismatch++;
    give_verdict();
  endtask

  initial begin
    {rtc_sec_i, rtc_min_i, rtc_hour_i, rtc_day_i} = lfsr;
    repeat (16) @(posedge clk_i);
    #1 reset_i = 1'b0;
    factory_init_i = 1'b0;
    i_host.rd(FLAGS_ADDR, d); `CHK(d, FLAGS_RESET)
    i_host.rd(CAL_ADDR, d); `CHK(d, NV_RESET)
    i_host.rd(INT_CFG_ADDR, d); `CHK(d, NV_RESET)
    `CHK(osc_run_o, 1'b1)
    // Power-on with the crystal held still
    supply_ok_i = 1'b1;
    wait_for(1'b0, 40);
    i_host.rd(FLAGS_ADDR, d); `CHK(d, 8'h10)
    // Mid-run reset keeps the fail flag
    reset_i = 1'b1;
    repeat (2) @(posedge clk_i);
    #1 reset_i = 1'b0;
    i_host.rd(FLAGS_ADDR, d); `CHK(d, 8'h10)
    osc_on = 1'b1;
    // fail flag clear sequence, first write refused
    i_host.wr(FLAGS_ADDR, 8'h02);
    i_host.rd(FLAGS_ADDR, d); `CHK(d, 8'h12)
    i_host.wr(FLAGS_ADDR, 8'h02);
    i_host.wr(FLAGS_ADDR, 8'h00);
    i_host.rd(FLAGS_ADDR, d); `CHK(d, 8'h00)
    for (int w = 0; w < 2; w++) begin
      for (int i = 0; i < 4; i++) begin
        lfsr = lfsr_next(lfsr);
        v = lfsr[7:0];
        if (i == 0) v[ALARM_MASK] = 1'b0;
        i_host.wr(ALARM_SEC_ADDR + 15'(i), v);
        i_host.rd(ALARM_SEC_ADDR + 15'(i), d); `CHK(d, (w == 1) ? v : ALARM_RESET)
      end
      i_host.wr(FLAGS_ADDR, {6'h00, w == 0, 1'b0});
    end
    i_host.wr(CAL_ADDR, 8'hff);
    fork
      i_host.rd(CAL_ADDR, d);
      begin
        repeat (2) @(posedge clk_i);
        #1 `CHK(dq_oe_o, 1'b1)
      end
    join
    `CHK(d, CAL_WMASK)
    #1 `CHK(dq_oe_o, 1'b0)
    `CHK(osc_run_o, 1'b0)
    i_host.wr(CAL_ADDR, 8'h00);
    `CHK(osc_run_o, 1'b1)
    // Test wave: bit 5 of the divider, 64 core cycles a half period
    i_host.wr(FLAGS_ADDR, 8'h02);
    i_host.wr(FLAGS_ADDR, 8'h06);
    tog = 0;
    seen = int_o ^ int_oe_o;
    repeat (600) begin
      @(posedge clk_i) #1;
      if ((int_o ^ int_oe_o) !== seen) tog++;
      seen = int_o ^ int_oe_o;
    end
    `CHK(tog >= 9 && tog <= 10, 1'b1)
    i_host.wr(FLAGS_ADDR, 8'h02);
    i_host.wr(FLAGS_ADDR, 8'h00);
    foreach (cfgs[k]) begin
      hl = cfgs[k][INT_HL];
      i_host.wr(INT_CFG_ADDR, cfgs[k]);
      i_host.rd(INT_CFG_ADDR, d); `CHK(d, cfgs[k])
      @(posedge clk_i) #1 supply_fail_i = 1'b1;
      repeat (2) @(posedge clk_i);
      #1 `CHK(asserted(hl, int_o, int_oe_o), 1'b1)
      repeat (PULSE + 4) @(posedge clk_i);
      #1 `CHK(asserted(hl, int_o, int_oe_o), ~cfgs[k][INT_PL])
      supply_fail_i = 1'b0;
      i_host.rd(FLAGS_ADDR, d); `CHK(d, 8'h20)
      `CHK(asserted(hl, int_o, int_oe_o), 1'b0)
      i_host.rd(FLAGS_ADDR, d); `CHK(d, 8'h00)
    end
    // lock toggled by the host around each load
    i_host.wr(WDOG_ADDR, 8'h00);
    i_host.wr(WDOG_ADDR, 8'h41);
    i_host.wr(WDOG_ADDR, 8'h05);
    i_host.rd(WDOG_ADDR, d); `CHK(d, 8'h01)
    i_host.wr(INT_CFG_ADDR, 8'h88);
    i_host.wr(WDOG_ADDR, 8'hc1);
    wait_for(1'b1, 9000);
    i_host.rd(FLAGS_ADDR, d); `CHK(d, 8'h80)
    // Zero load locked in while the strobe reloads the old value of 1
    i_host.wr(WDOG_ADDR, 8'h00);
    i_host.wr(WDOG_ADDR, 8'hc0);
    i_host.rd(WDOG_ADDR, d); `CHK(d, 8'h40)
    seen = 1'b0;
    repeat (10000) @(posedge clk_i) #1 seen |= int_o;
    `CHK(seen, 1'b0)
    // Seconds and minutes compared, hours and day masked with wrong values
    i_host.wr(FLAGS_ADDR, 8'h02);
    i_host.wr(ALARM_SEC_ADDR, {1'b0, rtc_sec_i[6:0]});
    i_host.wr(ALARM_MIN_ADDR, {1'b0, rtc_min_i[6:0]});
    i_host.wr(ALARM_HR_ADDR, {1'b1, ~rtc_hour_i[6:0]});
    i_host.wr(ALARM_DAY_ADDR, {1'b1, ~rtc_day_i[6:0]});
    i_host.wr(FLAGS_ADDR, 8'h00);
    i_host.wr(INT_CFG_ADDR, 8'h48);
    wait_for(1'b1, 70000);
    i_host.rd(FLAGS_ADDR, d); `CHK(d, 8'h40)
    `CHK(int_o, 1'b0)
    give_verdict();
  end
endmodule
`undef CHK
`default_nettype wire
